// [logic/lkt_defs.vh]
// Constants for the serial link transceiver
`ifndef LKT_DEFS_VH
`define LKT_DEFS_VH
`define LKT_WORD_W       10
`define LKT_PER_W        16
`define LKT_BIT_MULT     16'h000a
`define LKT_BIT_LAST     4'h9
`define LKT_BCLK_FALL    4'h4
`define LKT_COMMA_NEG    10'h0fa
`define LKT_COMMA_POS    10'h305
`define LKT_ADDR_STATUS  12'h000
`define LKT_ADDR_MASK    12'h004
`define LKT_ADDR_STATE   12'h008
`define LKT_EV_W         4
`define LKT_EV_COMMA     0
`define LKT_EV_SIG_UP    1
`define LKT_EV_SIG_DN    2
`define LKT_EV_WORD      3
`define LKT_MASK_RST     4'h0
`define LKT_ST_ALIGNED   16
`define LKT_ST_SIGNAL_DETECT_FLAG    17
`define LKT_ST_LOOP      18
`define LKT_ST_COMMA_EN  19
`endif

// [logic/lkt_nco.v]
// Rate measurement and bit-tick generator (ten bits per measured period)
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.vh"
module lkt_nco #(
  parameter HALF = 0
) (
  input  wire                  clk,     // System clock
  input  wire                  rst,     // Async reset, active high
  input  wire                  ref_rise,// Rising edge of rate reference
  input  wire                  realign, // Restart bit phase
  output reg                   tick,    // One pulse per bit time
  output reg  [`LKT_PER_W-1:0] period   // Reference period in cycles
);
  reg  [`LKT_PER_W-1:0] cnt_q;
  reg  [`LKT_PER_W-1:0] acc_q;
  wire [`LKT_PER_W:0]   acc_nx = {1'b0, acc_q} + {1'b0, `LKT_BIT_MULT};
  wire [`LKT_PER_W-1:0] start  = HALF ? (period >> 1) : {`LKT_PER_W{1'b0}};
  wire                  wrap   = (period != {`LKT_PER_W{1'b0}}) &&
                                 (acc_nx >= {1'b0, period});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= {`LKT_PER_W{1'b0}};
      acc_q  <= {`LKT_PER_W{1'b0}};
      period <= {`LKT_PER_W{1'b0}};
      tick   <= 1'b0;
    end else begin
      if (ref_rise) begin
        period <= cnt_q + 16'h0001;
        cnt_q  <= {`LKT_PER_W{1'b0}};
      end else if (cnt_q != {`LKT_PER_W{1'b1}}) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      // Transmit restart is itself the first bit boundary of the word
      tick <= (wrap && !realign) ||
              (realign && (HALF == 0) && (period != {`LKT_PER_W{1'b0}}));
      if (realign) begin
        acc_q <= start;
      end else if (wrap) begin
        acc_q <= acc_nx[`LKT_PER_W-1:0] - period;
      end else begin
        acc_q <= acc_nx[`LKT_PER_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// [logic/lkt_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lkt_sync #(
  parameter W = 1
) (
  input  wire         clk,   // Sampling clock
  input  wire         rst,   // Async reset, active high
  input  wire [W-1:0] din,   // Asynchronous inputs
  output reg  [W-1:0] dout   // Filtered, synchronous
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/lkt_transceiver.v]
// Serial link transmitter and receiver with APB status block
//
// Function
// - Transmit bit clock is byte clock times ten
// - Capture transmit word on byte clock rise
// - Load strobe moves word into serializer
// - Serialize most significant bit first
// - Loopback select steers serial output pair
// - Unselected output pair held low
// - Receive mux follows loopback select
// - Recover bit timing, retime received data
// - Signal detect follows optical signal present
// - Assemble words, first bit into bit nine
// - Comma alignment sets flag and realigns
// - Receive byte clock at word rate
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.vh"
module lkt_transceiver (
  input  wire        MCLK,                     // System clock
  input  wire        RST,                      // Async reset
  input  wire        PSEL,                     // APB select
  input  wire        PENABLE,                  // APB enable
  input  wire        PWRITE,                   // APB write
  input  wire [11:0] PADDR,                    // APB address
  input  wire [31:0] PWDATA,                   // APB write data
  output reg  [31:0] PRDATA,                   // APB read data
  output reg         PREADY,                   // APB ready
  output reg         PSLVERR,                  // APB error
  output reg         IRQ,                      // Interrupt, level
  input  wire        TX_BYTE_CLOCK,            // Transmit byte clock
  input  wire [9:0]  TX_PARALLEL_WORD,         // Transmit word
  input  wire        LOOPBACK_SELECT,          // 1 selects loop pair
  output reg         LINE_SERIAL_OUT_P,        // Line out, true
  output reg         LINE_SERIAL_OUT_N,        // Line out, complement
  output reg         LOOP_SERIAL_OUT_P,        // Loop out, true
  output reg         LOOP_SERIAL_OUT_N,        // Loop out, complement
  input  wire        LINE_SERIAL_IN_P,         // Line in, true
  input  wire        LINE_SERIAL_IN_N,         // Line in, complement
  input  wire        LOOP_SERIAL_IN_P,         // Loop in, true
  input  wire        LOOP_SERIAL_IN_N,         // Loop in, complement
  input  wire        OPTICAL_SIGNAL_PRESENT_P, // Signal present, true
  input  wire        OPTICAL_SIGNAL_PRESENT_N, // Signal present, compl.
  output reg         SIGNAL_DETECT_FLAG,       // Signal detect
  input  wire        REFERENCE_CLOCK,          // Receive rate reference
  input  wire        COMMA_ALIGN_ENABLE,       // Allow realignment
  output reg         RX_BYTE_CLOCK,            // Receive byte clock
  output reg  [9:0]  RX_PARALLEL_WORD,         // Receive word
  output reg         COMMA_ALIGNED             // Aligned flag
);

  // Pin synchronisation
  wire [19:0] pins_async = {
    TX_BYTE_CLOCK,
    TX_PARALLEL_WORD,
    LOOPBACK_SELECT,
    LINE_SERIAL_IN_P,
    LINE_SERIAL_IN_N,
    LOOP_SERIAL_IN_P,
    LOOP_SERIAL_IN_N,
    OPTICAL_SIGNAL_PRESENT_P,
    OPTICAL_SIGNAL_PRESENT_N,
    REFERENCE_CLOCK,
    COMMA_ALIGN_ENABLE
  };
  wire [19:0] pins;

  lkt_sync #(
    .W (20)
  ) u_sync (
    .clk  (MCLK),
    .rst  (RST),
    .din  (pins_async),
    .dout (pins)
  );

  wire       tx_byte_clock    = pins[19];
  wire [9:0] tx_parallel_word = pins[18:9];
  wire       loopback_select  = pins[8];
  wire       line_in          = pins[7] & ~pins[6];
  wire       loop_in          = pins[5] & ~pins[4];
  wire       sig_present      = pins[3] & ~pins[2];
  wire       reference_clock  = pins[1];
  wire       comma_align_en   = pins[0];

  // Edge detection on synchronised clocks
  reg  txc_q;
  reg  refc_q;
  wire tx_rise  = tx_byte_clock & ~txc_q;
  wire ref_rise = reference_clock & ~refc_q;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      txc_q  <= 1'b0;
      refc_q <= 1'b0;
    end else begin
      txc_q  <= tx_byte_clock;
      refc_q <= reference_clock;
    end
  end

  // ---------------- Transmit path ----------------
  wire                  tx_bit_tick;

  // Bit ticks at ten per byte clock period
  lkt_nco #(
    .HALF (0)
  ) u_tx_nco (
    .clk      (MCLK),
    .rst      (RST),
    .ref_rise (tx_rise),
    .realign  (tx_rise),
    .tick     (tx_bit_tick),
    .period   ()
  );

  reg [9:0] tx_in_q;
  reg [9:0] tx_sh_q;
  reg [3:0] tx_cnt_q;
  reg       tx_bit_q;
  wire      serializer_load_strobe = tx_bit_tick && !tx_rise && (tx_cnt_q == 4'h0);

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx_in_q <= 10'h000;
    end else if (tx_rise) begin
      tx_in_q <= tx_parallel_word;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx_sh_q  <= 10'h000;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 1'b0;
    end else begin
      if (tx_rise) begin
        tx_cnt_q <= 4'h0;
      end else if (tx_bit_tick) begin
        if (serializer_load_strobe) begin
          tx_sh_q  <= {tx_in_q[8:0], 1'b0};
          tx_bit_q <= tx_in_q[9];
        end else begin
          tx_sh_q  <= {tx_sh_q[8:0], 1'b0};
          tx_bit_q <= tx_sh_q[9];
        end
        if (tx_cnt_q == `LKT_BIT_LAST) begin
          tx_cnt_q <= 4'h0;
        end else begin
          tx_cnt_q <= tx_cnt_q + 4'h1;
        end
      end
    end
  end

  // Output pair steering
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      LINE_SERIAL_OUT_P <= 1'b0;
      LINE_SERIAL_OUT_N <= 1'b0;
      LOOP_SERIAL_OUT_P <= 1'b0;
      LOOP_SERIAL_OUT_N <= 1'b0;
    end else if (loopback_select) begin
      LOOP_SERIAL_OUT_P <= tx_bit_q;
      LOOP_SERIAL_OUT_N <= ~tx_bit_q;
      LINE_SERIAL_OUT_P <= 1'b0;
      LINE_SERIAL_OUT_N <= 1'b0;
    end else begin
      LINE_SERIAL_OUT_P <= tx_bit_q;
      LINE_SERIAL_OUT_N <= ~tx_bit_q;
      LOOP_SERIAL_OUT_P <= 1'b0;
      LOOP_SERIAL_OUT_N <= 1'b0;
    end
  end

  // ---------------- Receive path ----------------
  reg  rxd_q;
  reg  rxd_prev_q;
  wire rx_edge = rxd_q ^ rxd_prev_q;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rxd_q      <= 1'b0;
      rxd_prev_q <= 1'b0;
    end else begin
      rxd_q      <= loopback_select ? loop_in : line_in;
      rxd_prev_q <= rxd_q;
    end
  end

  wire                  rx_bit_tick;

  // Reference sets bit length; data edges set mid-bit phase
  lkt_nco #(
    .HALF (1)
  ) u_rx_nco (
    .clk      (MCLK),
    .rst      (RST),
    .ref_rise (ref_rise),
    .realign  (rx_edge),
    .tick     (rx_bit_tick),
    .period   ()
  );

  reg  [9:0] rx_sh_q;
  reg  [3:0] rx_cnt_q;
  wire [9:0] rx_sh_d = {rx_sh_q[8:0], rxd_q};
  wire       comma   = (rx_sh_d == `LKT_COMMA_NEG) ||
                       (rx_sh_d == `LKT_COMMA_POS);
  reg        ev_comma;
  reg        ev_word;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_sh_q          <= 10'h000;
      rx_cnt_q         <= 4'h0;
      RX_PARALLEL_WORD <= 10'h000;
      RX_BYTE_CLOCK    <= 1'b0;
      COMMA_ALIGNED    <= 1'b0;
      ev_comma         <= 1'b0;
      ev_word          <= 1'b0;
    end else begin
      ev_comma <= 1'b0;
      ev_word  <= 1'b0;
      if (!comma_align_en) begin
        COMMA_ALIGNED <= 1'b0;
      end
      if (rx_bit_tick) begin
        rx_sh_q <= rx_sh_d;
        if (comma_align_en && comma) begin
          RX_PARALLEL_WORD <= rx_sh_d;
          rx_cnt_q         <= 4'h0;
          RX_BYTE_CLOCK    <= 1'b1;
          COMMA_ALIGNED    <= 1'b1;
          ev_comma         <= 1'b1;
          ev_word          <= 1'b1;
        end else if (rx_cnt_q == `LKT_BIT_LAST) begin
          RX_PARALLEL_WORD <= rx_sh_d;
          rx_cnt_q         <= 4'h0;
          RX_BYTE_CLOCK    <= 1'b1;
          COMMA_ALIGNED    <= 1'b0;
          ev_word          <= 1'b1;
        end else begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          // Fall mid-word so the word is stable there
          if (rx_cnt_q == `LKT_BCLK_FALL) begin
            RX_BYTE_CLOCK <= 1'b0;
          end
        end
      end
    end
  end

  // Signal detect
  reg ev_sig_up;
  reg ev_sig_dn;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SIGNAL_DETECT_FLAG <= 1'b0;
      ev_sig_up          <= 1'b0;
      ev_sig_dn          <= 1'b0;
    end else begin
      SIGNAL_DETECT_FLAG <= sig_present;
      ev_sig_up          <= sig_present & ~SIGNAL_DETECT_FLAG;
      ev_sig_dn          <= ~sig_present & SIGNAL_DETECT_FLAG;
    end
  end

  // ---------------- Status, mask, APB ----------------
  wire [`LKT_EV_W-1:0] events;

  assign events[`LKT_EV_COMMA]  = ev_comma;
  assign events[`LKT_EV_SIG_UP] = ev_sig_up;
  assign events[`LKT_EV_SIG_DN] = ev_sig_dn;
  assign events[`LKT_EV_WORD]   = ev_word;

  reg  [`LKT_EV_W-1:0] status_q;
  reg  [`LKT_EV_W-1:0] mask_q;
  reg  [`LKT_EV_W-1:0] clr_q;
  wire                 apb_acc  = PSEL & PENABLE;
  wire                 apb_done = apb_acc & PREADY;
  wire                 hit_st   = (PADDR == `LKT_ADDR_STATUS);
  wire                 hit_mk   = (PADDR == `LKT_ADDR_MASK);
  wire                 hit_sa   = (PADDR == `LKT_ADDR_STATE);
  reg  [31:0]          rd_d;

  always @* begin
    rd_d = 32'h00000000;
    if (hit_st) begin
      rd_d[`LKT_EV_W-1:0] = status_q;
    end else if (hit_mk) begin
      rd_d[`LKT_EV_W-1:0] = mask_q;
    end else if (hit_sa) begin
      rd_d[9:0]              = RX_PARALLEL_WORD;
      rd_d[`LKT_ST_ALIGNED]  = COMMA_ALIGNED;
      rd_d[`LKT_ST_SIGNAL_DETECT_FLAG]   = SIGNAL_DETECT_FLAG;
      rd_d[`LKT_ST_LOOP]     = loopback_select;
      rd_d[`LKT_ST_COMMA_EN] = comma_align_en;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
      clr_q   <= {`LKT_EV_W{1'b0}};
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      if (apb_acc && !PREADY) begin
        PREADY  <= 1'b1;
        PSLVERR <= ~(hit_st | hit_mk | hit_sa);
        PRDATA  <= PWRITE ? 32'h00000000 : rd_d;
        // Only bits actually reported are cleared later
        clr_q   <= (!PWRITE && hit_st) ? status_q : {`LKT_EV_W{1'b0}};
      end
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      status_q <= {`LKT_EV_W{1'b0}};
      mask_q   <= `LKT_MASK_RST;
      IRQ      <= 1'b0;
    end else begin
      // Set wins over read-clear
      if (apb_done && !PWRITE && hit_st) begin
        status_q <= (status_q & ~clr_q) | events;
      end else begin
        status_q <= status_q | events;
      end
      if (apb_done && PWRITE && hit_mk) begin
        mask_q <= PWDATA[`LKT_EV_W-1:0];
      end
      IRQ <= |(status_q & mask_q);
    end
  end

endmodule
`default_nettype wire

// [tb/lkt_partner.sv]
// Encoder, reference oscillator and optical module model
`timescale 1ns/1ps
`default_nettype none
module lkt_partner (
  input  wire logic       sig_on,   // Light present
  output var  logic       byte_clk, // Tx byte clock
  output var  logic       ref_clk,  // Rate reference
  output var  logic [9:0] tx_word,  // Encoded word
  output wire logic       sig_p,    // Present, true
  output wire logic       sig_n     // Present, compl.
);
  logic [9:0] seq [4] = '{10'h0fa, 10'h2a5, 10'h305, 10'h15a};
  int         idx = 0;
  initial begin
    byte_clk = 1'b0;
    tx_word = seq[0];
    forever #80 byte_clk = ~byte_clk;
  end
  // New word half a period before the capturing rise
  always @(negedge byte_clk) begin
    idx = (idx + 1) % 4;
    tx_word = seq[idx];
  end
  initial begin
    ref_clk = 1'b0;
    #37;
    forever #80 ref_clk = ~ref_clk;
  end
  assign sig_p = sig_on;
  assign sig_n = ~sig_on;
endmodule
`default_nettype wire

// [tb/lkt_transceiver_asserts.sv]
// Port-level checker for the serial link transceiver
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.vh"
module lkt_transceiver_asserts (
  input wire logic       MCLK,                     // Clock
  input wire logic       RST,                      // Reset
  input wire logic       PSEL,                     // APB select
  input wire logic       PENABLE,                  // APB enable
  input wire logic       PREADY,                   // APB ready
  input wire logic       PSLVERR,                  // APB error
  input wire logic       LOOPBACK_SELECT,          // Pair select
  input wire logic       LINE_SERIAL_OUT_P,        // Line out
  input wire logic       LINE_SERIAL_OUT_N,        // Line out
  input wire logic       LOOP_SERIAL_OUT_P,        // Loop out
  input wire logic       LOOP_SERIAL_OUT_N,        // Loop out
  input wire logic       OPTICAL_SIGNAL_PRESENT_P, // Light in
  input wire logic       OPTICAL_SIGNAL_PRESENT_N, // Light in
  input wire logic       SIGNAL_DETECT_FLAG,       // Detect
  input wire logic       COMMA_ALIGN_ENABLE,       // Align enable
  input wire logic       RX_BYTE_CLOCK,            // Rx byte clock
  input wire logic [9:0] RX_PARALLEL_WORD,         // Rx word
  input wire logic       COMMA_ALIGNED             // Aligned flag
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire       lit = OPTICAL_SIGNAL_PRESENT_P & ~OPTICAL_SIGNAL_PRESENT_N;
  logic [5:0] off_q;
  // Cycles with alignment disabled, saturating
  always @(posedge MCLK or posedge RST) begin
    if (RST) off_q <= 6'h00;
    else if (COMMA_ALIGN_ENABLE) off_q <= 6'h00;
    else if (off_q != 6'h3f) off_q <= off_q + 6'h01;
  end
  a_line_idle: assert property (LOOPBACK_SELECT[*8] |-> !LINE_SERIAL_OUT_P && !LINE_SERIAL_OUT_N)
    else $error("line pair active while loop selected");
  a_loop_idle: assert property ((!LOOPBACK_SELECT)[*8] |-> !(LOOP_SERIAL_OUT_P|LOOP_SERIAL_OUT_N))
    else $error("loop pair active while line selected");
  a_detect_on: assert property (lit[*8] |-> SIGNAL_DETECT_FLAG)
    else $error("signal detect low with light");
  a_detect_off: assert property ((!lit)[*8] |-> !SIGNAL_DETECT_FLAG)
    else $error("signal detect high without light");
  a_align_off: assert property (off_q > 6'h1e |-> !COMMA_ALIGNED)
    else $error("aligned flag high while disabled");
  a_align_word: assert property ($rose(COMMA_ALIGNED) |-> RX_BYTE_CLOCK &&
    (RX_PARALLEL_WORD == `LKT_COMMA_NEG || RX_PARALLEL_WORD == `LKT_COMMA_POS))
    else $error("aligned flag without comma word");
  a_clock_high: assert property ($rose(RX_BYTE_CLOCK) |-> RX_BYTE_CLOCK[*6] ##[1:24] !RX_BYTE_CLOCK)
    else $error("rx byte clock high phase wrong");
  a_word_hold: assert property (!RX_BYTE_CLOCK |-> $stable(RX_PARALLEL_WORD))
    else $error("rx word moved while clock low");
  a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not after one wait state");
  cover property ($rose(COMMA_ALIGNED));
  cover property ($rose(SIGNAL_DETECT_FLAG));
  cover property (PREADY && PSLVERR);
endmodule
bind lkt_transceiver lkt_transceiver_asserts lkt_transceiver_asserts_inst (.*);
`default_nettype wire

// [tb/lkt_transceiver_tb.sv]
// Self-checking bench for the serial link transceiver
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.vh"
module lkt_transceiver_tb;
  logic        MCLK, RST, PSEL, PENABLE, PWRITE, LOOPBACK_SELECT, COMMA_ALIGN_ENABLE, sig, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, r;
  logic [9:0]  w;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, IRQ, SIGNAL_DETECT_FLAG, RX_BYTE_CLOCK, COMMA_ALIGNED;
  wire         LINE_SERIAL_OUT_P, LINE_SERIAL_OUT_N, LOOP_SERIAL_OUT_P, LOOP_SERIAL_OUT_N;
  wire         TX_BYTE_CLOCK, REFERENCE_CLOCK, OPTICAL_SIGNAL_PRESENT_P, OPTICAL_SIGNAL_PRESENT_N;
  wire  [9:0]  TX_PARALLEL_WORD, RX_PARALLEL_WORD;
  // Medium and loop cable run straight back
  wire         LINE_SERIAL_IN_P = LINE_SERIAL_OUT_P;
  wire         LINE_SERIAL_IN_N = LINE_SERIAL_OUT_N;
  wire         LOOP_SERIAL_IN_P = LOOP_SERIAL_OUT_P;
  wire         LOOP_SERIAL_IN_N = LOOP_SERIAL_OUT_N;
  int          err_count = 0, cmp_count = 0, cyc = 0, n;
  // Rows: loop select, light, align enable
  logic [2:0]  rows [4] = '{3'b011, 3'b101, 3'b110, 3'b000};
  lkt_transceiver lkt_transceiver_inst (.*);
  lkt_partner lkt_partner_inst (.sig_on(sig), .byte_clk(TX_BYTE_CLOCK),
    .ref_clk(REFERENCE_CLOCK), .tx_word(TX_PARALLEL_WORD),
    .sig_p(OPTICAL_SIGNAL_PRESENT_P), .sig_n(OPTICAL_SIGNAL_PRESENT_N));
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    chk(k < 20, 1, "no ready");
  endtask
  task wait_fall;
    int k;
    k = 0;
    while (RX_BYTE_CLOCK !== 1'b1 && k < 60) begin
      @(posedge MCLK);
      k++;
    end
    while (RX_BYTE_CLOCK !== 1'b0 && k < 60) begin
      @(posedge MCLK);
      k++;
    end
    chk(k < 60, 1, "rx byte clock stuck");
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("CHECK FAILED %0t timeout", $time);
      stop_test;
    end
  end
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    LOOPBACK_SELECT = 1'b0;
    COMMA_ALIGN_ENABLE = 1'b1;
    sig = 1'b0;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    apb(0, `LKT_ADDR_MASK, 0);
    chk(r, 0, "mask reset value");
    apb(1, `LKT_ADDR_MASK, 32'h5);
    apb(0, `LKT_ADDR_MASK, 0);
    chk(r, 32'h5, "mask read back");
    apb(0, 12'h00c, 0);
    chk(r, 0, "unmapped data");
    chk(e, 1, "unmapped error");
    apb(1, `LKT_ADDR_MASK, 0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      {LOOPBACK_SELECT, sig, COMMA_ALIGN_ENABLE} <= rows[i];
      // Synchronisers plus one word boundary
      repeat (40) @(posedge MCLK);
      chk(SIGNAL_DETECT_FLAG, rows[i][1], "signal detect");
      apb(0, `LKT_ADDR_STATE, 0);
      chk(r[19:17], {rows[i][0], rows[i][2], rows[i][1]}, "state pins");
      n = 0;
      // Start from a fresh alignment so the byte clock is still high
      while (COMMA_ALIGNED === 1'b1 && n < 300) begin
        @(posedge MCLK);
        n++;
      end
      while (COMMA_ALIGNED !== 1'b1 && n < 300) begin
        @(posedge MCLK);
        n++;
      end
      chk(n < 300, rows[i][0], "aligned flag");
      if (rows[i][0]) begin
        wait_fall;
        w = RX_PARALLEL_WORD;
        chk(w == `LKT_COMMA_NEG || w == `LKT_COMMA_POS, 1, "comma word");
        wait_fall;
        chk(RX_PARALLEL_WORD, w == `LKT_COMMA_NEG ? 10'h2a5 : 10'h15a, "next word");
      end
      $display("test pins %0d done", i);
    end
    apb(0, `LKT_ADDR_STATUS, 0);
    apb(1, `LKT_ADDR_MASK, 32'h2);
    repeat (2) @(posedge MCLK);
    chk(IRQ, 0, "irq idle");
    sig <= 1'b1;
    repeat (20) @(posedge MCLK);
    chk(IRQ, 1, "irq raised");
    apb(0, `LKT_ADDR_STATUS, 0);
    chk(r[1], 1, "light rise event");
    repeat (3) @(posedge MCLK);
    chk(IRQ, 0, "irq cleared");
    apb(1, `LKT_ADDR_MASK, 0);
    sig <= 1'b0;
    repeat (20) @(posedge MCLK);
    chk(IRQ, 0, "irq masked");
    apb(0, `LKT_ADDR_STATUS, 0);
    chk(r[2], 1, "light fall event");
    $display("test interrupt done");
    sig <= 1'b1;
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk({IRQ, SIGNAL_DETECT_FLAG, COMMA_ALIGNED, PREADY}, 0, "outputs in reset");
    RST <= 1'b0;
    apb(0, `LKT_ADDR_MASK, 0);
    chk(r, 0, "mask after reset");
    $display("test reset done");
    stop_test;
  end
endmodule
`default_nettype wire
